// ---- bench/sdl_dma_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the dma link controller
// Assumes: zero-wait apb slave, datapath model on the far side
// Notes: every scenario is its own task
module sdl_dma_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdl_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = 12'h000;
  logic [DW-1:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [SEQ_W-1:0] seq_state = 3'h0;
  sdl_dp_in_t ext = '0;
  sdl_dp_in_t dp_in;
  sdl_dp_out_t dp_out;
  logic [NEV-1:0] irq_masked;
  logic [3:0] lat = 4'h0;
  logic fail = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [DW-1:0] q;
  logic e;
  always #20 pclk = ~pclk;
  sdl_dma_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seq_state(seq_state), .dp_in(dp_in), .dp_out(dp_out),
    .irq_masked(irq_masked));
  sdl_dp_model far (.pclk(pclk), .presetn(presetn), .dp_out(dp_out),
    .ext(ext), .lat(lat), .fail(fail), .dp_in(dp_in));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [AW-1:0] a,
      input logic [DW-1:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic step;
    @(posedge pclk);
    ext <= '0;
  endtask : step
  task automatic wfetch(input logic rx, input logic [LK_AW-1:0] a);
    repeat (8) if ((rx ? dp_out.rx_fetch : dp_out.tx_fetch) !== 1'b1)
      @(posedge pclk);
    chk(rx ? dp_out.rx_fetch : dp_out.tx_fetch, 1);
    chk(rx ? dp_out.rx_addr : dp_out.tx_addr, a);
  endtask : wfetch
  task automatic wrun(input logic rx, input logic v);
    repeat (12) if ((rx ? dp_out.rx_run : dp_out.tx_run) !== v)
      @(posedge pclk);
    chk(rx ? dp_out.rx_run : dp_out.tx_run, v);
  endtask : wrun
  task automatic t_reset;
    logic [AW-1:0] offs [6] = '{OFF_CONF, OFF_TXL, OFF_RXL, OFF_STAT,
                                OFF_ENA, OFF_RAW};
    chk(dp_out, 0);
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      chk(q, 0);
    end
  endtask : t_reset
  task automatic t_seq;
    for (int s = 0; s < 8; s++) begin
      seq_state <= s[SEQ_W-1:0];
      apb(1'b0, OFF_SEQ, 32'h0);
      chk(q, s);
    end
  endtask : t_seq
  task automatic t_conf;
    int b [7] = '{CF_DATA_BURST, CF_TXD_BURST, CF_RXD_BURST, CF_BM_RST,
                  CF_FIFO_RST, CF_OUT_RST, CF_IN_RST};
    apb(1'b1, OFF_CONF, 32'hffff_ffff);
    apb(1'b0, OFF_CONF, 32'h0);
    chk(q, CONF_MASK);
    foreach (b[i]) begin
      apb(1'b1, OFF_CONF, 32'h1 << b[i]);
      repeat (3) @(posedge pclk);
      chk({dp_out.data_burst, dp_out.txd_burst, dp_out.rxd_burst,
           dp_out.bm_rst, dp_out.fifo_rst, dp_out.out_rst,
           dp_out.in_rst}, 7'h40 >> i);
    end
    apb(1'b1, OFF_CONF, 32'h0);
    chk(dp_out.in_rst, 0);
  endtask : t_conf
  task automatic t_tx;
    apb(1'b1, OFF_TXL, 32'h2001_2344);
    wfetch(1'b0, 20'h12344);
    wrun(1'b0, 1'b1);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(q, 32'h2);
    lat <= 4'h3;
    ext.tx_desc_done <= 1'b1;
    step;
    wrun(1'b0, 1'b0);
    apb(1'b1, OFF_TXL, 32'h4001_2344);
    wfetch(1'b0, 20'h12344);
    wrun(1'b0, 1'b1);
    apb(1'b1, OFF_TXL, 32'h1001_2344);
    wrun(1'b0, 1'b0);
  endtask : t_tx
  task automatic t_rx;
    fail <= 1'b1;
    apb(1'b1, OFF_RXL, 32'h2000_0abc);
    wfetch(1'b1, 20'h00abc);
    repeat (6) @(posedge pclk);
    fail <= 1'b0;
    apb(1'b0, OFF_RAW, 32'h0);
    chk(q, 32'h1 << EV_RX_DERR);
    apb(1'b0, OFF_MSK, 32'h0);
    chk(q, 0);
    apb(1'b1, OFF_ENA, 32'h1ff);
    apb(1'b0, OFF_MSK, 32'h0);
    chk(q, 32'h1 << EV_RX_DERR);
    apb(1'b1, OFF_CLR, 32'h1 << EV_RX_DERR);
    apb(1'b0, OFF_RAW, 32'h0);
    chk(q, 0);
    apb(1'b1, OFF_RXL, 32'h2010_0abc);
    wrun(1'b1, 1'b1);
    ext.rx_invalid <= 1'b1;
    ext.rx_next <= 20'h00def;
    step;
    wfetch(1'b1, 20'h00def);
    wrun(1'b1, 1'b1);
    ext.rx_desc_done <= 1'b1;
    step;
    apb(1'b1, OFF_RXL, 32'h4010_0def);
    wfetch(1'b1, 20'h00def);
    chk(irq_masked, 9'h011);
    apb(1'b1, OFF_RXL, 32'h1010_0def);
    wrun(1'b1, 1'b0);
    apb(1'b1, OFF_CLR, 32'h1ff);
    fork
      apb(1'b1, OFF_CLR, 32'h1 << EV_IN_DONE);
      begin
        @(posedge pclk);
        ext.rx_done <= 1'b1;
        @(posedge pclk);
        ext <= '0;
      end
    join
    apb(1'b0, OFF_RAW, 32'h0);
    chk(q, 32'h1 << EV_IN_DONE);
    apb(1'b1, OFF_CLR, 32'h1ff);
  endtask : t_rx
  task automatic t_eof;
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, OFF_CONF, 32'(m) << CF_EOF_MODE);
      ext.tx_pushed <= 1'b1;
      step;
      repeat (2) @(posedge pclk);
      apb(1'b0, OFF_RAW, 32'h0);
      chk(q[EV_OUT_EOF], m == 0);
      apb(1'b1, OFF_CLR, 32'h1ff);
      ext.tx_popped <= 1'b1;
      step;
      repeat (2) @(posedge pclk);
      apb(1'b0, OFF_RAW, 32'h0);
      chk(q[EV_OUT_EOF], m == 1);
      apb(1'b1, OFF_CLR, 32'h1ff);
    end
  endtask : t_eof
  task automatic t_cont;
    apb(1'b1, OFF_CONF, 32'h1_0000);
    apb(1'b1, OFF_TXL, 32'h2001_2344);
    wrun(1'b0, 1'b1);
    apb(1'b1, OFF_RXL, 32'h2000_0abc);
    wrun(1'b1, 1'b1);
    ext.tx_total_eof <= 1'b1;
    ext.rx_good_eof <= 1'b1;
    step;
    repeat (3) @(posedge pclk);
    chk({dp_out.tx_run, dp_out.rx_run}, 2'h3);
    apb(1'b0, OFF_RAW, 32'h0);
    chk(q, (32'h1 << EV_TOTAL_EOF) | (32'h1 << EV_IN_GOOD));
    apb(1'b1, OFF_CONF, 32'h1_8000);
    wrun(1'b0, 1'b0);
    chk(dp_out.rx_run, 1);
    apb(1'b1, OFF_CONF, 32'h1_c000);
    wrun(1'b1, 1'b0);
    apb(1'b1, OFF_STAT, 32'h3);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(q, 0);
    apb(1'b0, 12'h200, 32'h0);
    chk({e, q}, 33'h1_0000_0000);
  endtask : t_cont
  task automatic results;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial begin
    repeat (4000) @(posedge pclk);
    error_cnt++;
    $display("CHECK FAILED at %0t: timeout", $time);
    results;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_seq;
    t_conf;
    t_tx;
    t_rx;
    t_eof;
    t_cont;
    results;
  end
endmodule : sdl_dma_ctrl_tb_top

// ---- bench/sdl_dp_model.sv ----
// Purpose: far-side datapath stand-in answering descriptor fetches
// Assumes: same clock as the controller, one-cycle report pulses
// Notes: lat stretches the answer, fail turns it into a fault
module sdl_dp_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire sdl_pkg::sdl_dp_out_t dp_out,
  input wire sdl_pkg::sdl_dp_in_t ext,
  input wire logic [3:0] lat,
  input wire logic fail,
  output sdl_pkg::sdl_dp_in_t dp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdl_pkg::*;
  logic [4:0] tx_cnt_r;
  logic [4:0] rx_cnt_r;
  // a fetch arms a countdown; the answer pulses when it reaches one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_r <= 5'h00;
      rx_cnt_r <= 5'h00;
    end else begin
      tx_cnt_r <= dp_out.tx_fetch ? {1'b0, lat} + 5'h01 :
                  tx_cnt_r - {4'h0, |tx_cnt_r};
      rx_cnt_r <= dp_out.rx_fetch ? {1'b0, lat} + 5'h01 :
                  rx_cnt_r - {4'h0, |rx_cnt_r};
    end
  end
  always_comb begin
    dp_in = ext;
    dp_in.tx_desc_ok = ext.tx_desc_ok | (tx_cnt_r == 5'h01 && !fail);
    dp_in.tx_desc_err = ext.tx_desc_err | (tx_cnt_r == 5'h01 && fail);
    dp_in.rx_desc_ok = ext.rx_desc_ok | (rx_cnt_r == 5'h01 && !fail);
    dp_in.rx_desc_err = ext.rx_desc_err | (rx_cnt_r == 5'h01 && fail);
  end
endmodule : sdl_dp_model

// ---- logic/sdl_dma_ctrl.sv ----
// Purpose: register file and chain control of the spi descriptor dma
// Assumes: apb slave, zero wait states, datapath on the same clock
// Notes: reads are sampled in the setup phase
// How it works
// - sequencer state readable, codes zero to seven
// - continuous bit keeps transfers running
// - tx stop halts sending in continuous mode
// - rx stop halts receiving in continuous mode
// - data burst bit selects burst payload reads
// - separate burst bits for each descriptor chain
// - out eof on pop or push, per mode
// - bus master reset bit resets bus master
// - fifo reset bit resets master fifo pointers
// - out reset idles out machine, pointer kept
// - in reset idles in machine, pointer kept
// - tx restart resumes on appended descriptors
// - tx start fetches from programmed address
// - tx stop bit abandons tx descriptors
// - rx restart resumes on appended descriptors
// - rx start fetches from programmed address
// - rx stop bit abandons rx descriptors
// - auto skip advances past invalid packets
// - two read-only activity bits, tx and rx
// - nine event enable bits
// - masked status is raw and enable
// - clear bit per event, set wins
//
// The APB register port was left to the implementer.
module sdl_dma_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sdl_pkg::AW-1:0] paddr,
  input wire logic [sdl_pkg::DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [sdl_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [sdl_pkg::SEQ_W-1:0] seq_state,
  input wire sdl_pkg::sdl_dp_in_t dp_in,
  output sdl_pkg::sdl_dp_out_t dp_out,
  output logic [sdl_pkg::NEV-1:0] irq_masked
);
  import sdl_pkg::*;

  sdl_state_t r;
  sdl_state_t n;

  logic setup;
  logic wr;
  logic mapped;
  logic [DW-1:0] wd;
  logic [DW-1:0] rmux;
  logic [NEV-1:0] ev;
  logic [NEV-1:0] clr;
  logic tx_start;
  logic tx_stop;
  logic tx_restart;
  logic rx_start;
  logic rx_stop;
  logic rx_restart;
  logic cont;
  logic rx_skip;

  function automatic logic [DW-1:0] merge(logic [DW-1:0] old,
                                          logic [DW-1:0] neu,
                                          logic [3:0] strb);
    logic [DW-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = neu[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // one step of a descriptor chain; stop and path reset win over start
  function automatic sdl_chain_t chain_step(sdl_chain_t c, logic start,
      logic stop, logic restart, logic hold, logic [LK_AW-1:0] base,
      logic ok, logic err, logic done, logic [LK_AW-1:0] nxt,
      logic bounded_end);
    sdl_chain_t s;
    s = c;
    s.fetch = 1'b0;
    s.empty = 1'b0;
    if (hold || stop) begin
      s.st = CH_IDLE;
    end else if (start) begin
      s.ptr = base;
      s.st = CH_FETCH;
      s.fetch = 1'b1;
    end else begin
      case (c.st)
        CH_IDLE: begin
          s.st = CH_IDLE;
        end
        CH_FETCH: begin
          if (err) begin
            s.st = CH_IDLE;
          end else if (ok) begin
            s.st = CH_ACTIVE;
          end
        end
        CH_ACTIVE: begin
          if (bounded_end) begin
            s.st = CH_IDLE;
          end else if (done) begin
            if (nxt == '0) begin
              s.st = CH_HOLD;
              s.empty = 1'b1;
            end else begin
              s.ptr = nxt;
              s.st = CH_FETCH;
              s.fetch = 1'b1;
            end
          end
        end
        CH_HOLD: begin
          // re-read the last descriptor to pick up its new link
          if (restart) begin
            s.st = CH_FETCH;
            s.fetch = 1'b1;
          end
        end
        default: begin
          s.st = CH_IDLE;
        end
      endcase
    end
    return s;
  endfunction : chain_step

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign wd = pwdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = r.rdata;
  assign irq_masked = r.masked;
  assign cont = r.conf[CF_CONT];

  always_comb begin
    case (paddr)
      OFF_CRC, OFF_SEQ, OFF_CONF, OFF_TXL, OFF_RXL, OFF_STAT,
      OFF_ENA, OFF_RAW, OFF_MSK, OFF_CLR: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    rmux = '0;
    case (paddr)
      OFF_SEQ: begin
        rmux[SEQ_W-1:0] = seq_state;
      end
      OFF_CONF: begin
        rmux = r.conf;
      end
      OFF_TXL: begin
        rmux = r.txl;
      end
      OFF_RXL: begin
        rmux = r.rxl;
      end
      OFF_STAT: begin
        rmux[ST_TX] = dp_out.tx_run && r.tx.st == CH_ACTIVE;
        rmux[ST_RX] = dp_out.rx_run && r.rx.st == CH_ACTIVE;
      end
      OFF_ENA: begin
        rmux[NEV-1:0] = r.ena;
      end
      OFF_RAW: begin
        rmux[NEV-1:0] = r.raw;
      end
      OFF_MSK: begin
        rmux[NEV-1:0] = r.masked;
      end
      default: begin
        rmux = '0;
      end
    endcase
  end

  // chain commands act on the write itself, bit set means go
  always_comb begin
    tx_start = 1'b0;
    tx_stop = 1'b0;
    tx_restart = 1'b0;
    rx_start = 1'b0;
    rx_stop = 1'b0;
    rx_restart = 1'b0;
    clr = '0;
    if (wr && paddr == OFF_TXL) begin
      tx_start = pstrb[3] && wd[LK_START];
      tx_stop = pstrb[3] && wd[LK_STOP];
      tx_restart = pstrb[3] && wd[LK_RESTART];
    end
    if (wr && paddr == OFF_RXL) begin
      rx_start = pstrb[3] && wd[LK_START];
      rx_stop = pstrb[3] && wd[LK_STOP];
      rx_restart = pstrb[3] && wd[LK_RESTART];
    end
    if (wr && paddr == OFF_CLR) begin
      clr = NEV'(merge('0, wd, pstrb));
    end
  end

  assign rx_skip = r.rxl[LK_SKIP] && dp_in.rx_invalid;

  always_comb begin
    ev = '0;
    ev[EV_TOTAL_EOF] = dp_in.tx_total_eof;
    ev[EV_OUT_EOF] = r.conf[CF_EOF_MODE] ? dp_in.tx_popped
                                         : dp_in.tx_pushed;
    ev[EV_OUT_DONE] = dp_in.tx_done;
    ev[EV_IN_GOOD] = dp_in.rx_good_eof;
    ev[EV_IN_ERR] = dp_in.rx_invalid;
    ev[EV_IN_DONE] = dp_in.rx_done;
    ev[EV_RX_DERR] = dp_in.rx_desc_err;
    ev[EV_TX_DERR] = dp_in.tx_desc_err;
    ev[EV_RX_EMPTY] = r.rx.empty;
  end

  always_comb begin
    n = r;
    if (setup) begin
      n.rdata = rmux;
    end
    if (wr && paddr == OFF_CONF) begin
      n.conf = merge(r.conf, wd, pstrb) & CONF_MASK;
    end
    if (wr && paddr == OFF_TXL) begin
      n.txl = merge(r.txl, wd, pstrb) & TXL_MASK;
    end
    if (wr && paddr == OFF_RXL) begin
      n.rxl = merge(r.rxl, wd, pstrb) & RXL_MASK;
    end
    if (wr && paddr == OFF_ENA) begin
      n.ena = NEV'(merge({{(DW-NEV){1'b0}}, r.ena}, wd,
                         pstrb));
    end
    n.raw = (r.raw & ~clr[NEV-1:0]) | ev;
    n.masked = n.raw & n.ena;
    // the base pointer comes from the chain control register
    n.tx = chain_step(r.tx, tx_start, tx_stop, tx_restart,
                      r.conf[CF_OUT_RST], n.txl[LK_AW-1:0],
                      dp_in.tx_desc_ok, dp_in.tx_desc_err,
                      dp_in.tx_desc_done, dp_in.tx_next,
                      !cont && dp_in.tx_total_eof);
    n.rx = chain_step(r.rx, rx_start, rx_stop, rx_restart,
                      r.conf[CF_IN_RST], n.rxl[LK_AW-1:0],
                      dp_in.rx_desc_ok, dp_in.rx_desc_err,
                      dp_in.rx_desc_done || rx_skip, dp_in.rx_next,
                      !cont && dp_in.rx_good_eof);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.tx.st <= CH_IDLE;
      r.rx.st <= CH_IDLE;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    dp_out.tx_fetch = r.tx.fetch;
    dp_out.tx_addr = r.tx.ptr;
    dp_out.rx_fetch = r.rx.fetch;
    dp_out.rx_addr = r.rx.ptr;
    dp_out.tx_run = r.tx.st == CH_ACTIVE
                    && !(cont && r.conf[CF_TX_STOP]);
    dp_out.rx_run = r.rx.st == CH_ACTIVE
                    && !(cont && r.conf[CF_RX_STOP]);
    dp_out.data_burst = r.conf[CF_DATA_BURST];
    dp_out.txd_burst = r.conf[CF_TXD_BURST];
    dp_out.rxd_burst = r.conf[CF_RXD_BURST];
    dp_out.bm_rst = r.conf[CF_BM_RST];
    dp_out.fifo_rst = r.conf[CF_FIFO_RST];
    dp_out.out_rst = r.conf[CF_OUT_RST];
    dp_out.in_rst = r.conf[CF_IN_RST];
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence tx_start_wr;
    wr && paddr == OFF_TXL && pstrb == 4'hf && pwdata[LK_START]
    && !pwdata[LK_STOP] && !r.conf[CF_OUT_RST];
  endsequence

  sequence tx_fetch_issued(logic [LK_AW-1:0] a);
    dp_out.tx_fetch && dp_out.tx_addr == a;
  endsequence

  seq_read_a: assert property (setup && paddr == OFF_SEQ |=>
    prdata[SEQ_W-1:0] == $past(seq_state))
    else $error("sequencer state read wrong");
  tx_stop_a: assert property (cont && r.conf[CF_TX_STOP] |->
    !dp_out.tx_run)
    else $error("tx runs after stop");
  rx_stop_a: assert property (cont && r.conf[CF_RX_STOP] |->
    !dp_out.rx_run)
    else $error("rx runs after stop");
  out_eof_a: assert property (r.conf[CF_EOF_MODE] && dp_in.tx_popped
    |=> r.raw[EV_OUT_EOF])
    else $error("out eof not raised on pop");
  tx_start_a: assert property (tx_start_wr |=>
    tx_fetch_issued($past(pwdata[LK_AW-1:0])))
    else $error("tx start did not fetch base");
  tx_halt_a: assert property (wr && paddr == OFF_TXL && pstrb[3]
    && pwdata[LK_STOP] |=> r.tx.st == CH_IDLE ##1 !dp_out.tx_fetch)
    else $error("tx chain not stopped");
  out_hold_a: assert property (dp_out.out_rst [*2] |->
    r.tx.st == CH_IDLE && !dp_out.tx_run)
    else $error("out path not held in reset");
  rx_skip_a: assert property (r.rx.st == CH_ACTIVE && rx_skip
    && dp_in.rx_next != '0 && !rx_stop && !rx_start && !dp_out.in_rst
    && !(!cont && dp_in.rx_good_eof) |=> dp_out.rx_fetch
    && dp_out.rx_addr == $past(dp_in.rx_next))
    else $error("invalid packet not skipped");
  set_wins_a: assert property (ev[EV_IN_DONE] && clr[EV_IN_DONE]
    |=> r.raw[EV_IN_DONE])
    else $error("event lost to clear");
  masked_a: assert property (!(wr && paddr == OFF_ENA) |=>
    (irq_masked & $past(ev & r.ena)) == $past(ev & r.ena))
    else $error("masked status mismatch");
endmodule : sdl_dma_ctrl

// ---- logic/sdl_pkg.sv ----
// Purpose: shared constants and types for the spi dma link control block
// Assumes: apb register access, 32-bit data, byte addresses
// Notes: field positions inside each register are local choices
package sdl_pkg;
  localparam int AW = 12;
  localparam int DW = 32;
  // register byte offsets
  localparam logic [AW-1:0] OFF_CRC = 12'h0c0;
  localparam logic [AW-1:0] OFF_SEQ = 12'h0f8;
  localparam logic [AW-1:0] OFF_CONF = 12'h100;
  localparam logic [AW-1:0] OFF_TXL = 12'h104;
  localparam logic [AW-1:0] OFF_RXL = 12'h108;
  localparam logic [AW-1:0] OFF_STAT = 12'h10c;
  localparam logic [AW-1:0] OFF_ENA = 12'h110;
  localparam logic [AW-1:0] OFF_RAW = 12'h114;
  localparam logic [AW-1:0] OFF_MSK = 12'h118;
  localparam logic [AW-1:0] OFF_CLR = 12'h11c;
  // dma_configuration fields
  localparam int CF_IN_RST = 2;
  localparam int CF_OUT_RST = 3;
  localparam int CF_FIFO_RST = 4;
  localparam int CF_BM_RST = 5;
  localparam int CF_EOF_MODE = 9;
  localparam int CF_TXD_BURST = 10;
  localparam int CF_RXD_BURST = 11;
  localparam int CF_DATA_BURST = 12;
  localparam int CF_RX_STOP = 14;
  localparam int CF_TX_STOP = 15;
  localparam int CF_CONT = 16;
  localparam logic [DW-1:0] CONF_MASK = 32'h0001_de3c;
  // chain control fields
  localparam int LK_AW = 20;
  localparam int LK_SKIP = 20;
  localparam int LK_STOP = 28;
  localparam int LK_START = 29;
  localparam int LK_RESTART = 30;
  localparam logic [DW-1:0] TXL_MASK = 32'h700f_ffff;
  localparam logic [DW-1:0] RXL_MASK = 32'h701f_ffff;
  // activity status and sequencer state fields
  localparam int ST_RX = 0;
  localparam int ST_TX = 1;
  localparam int SEQ_W = 3;
  // event bit positions
  localparam int NEV = 9;
  localparam int EV_RX_EMPTY = 0;
  localparam int EV_TX_DERR = 1;
  localparam int EV_RX_DERR = 2;
  localparam int EV_IN_DONE = 3;
  localparam int EV_IN_ERR = 4;
  localparam int EV_IN_GOOD = 5;
  localparam int EV_OUT_DONE = 6;
  localparam int EV_OUT_EOF = 7;
  localparam int EV_TOTAL_EOF = 8;

  typedef enum logic [3:0] {
    CH_IDLE = 4'b0001,
    CH_FETCH = 4'b0010,
    CH_ACTIVE = 4'b0100,
    CH_HOLD = 4'b1000
  } sdl_chain_st_t;

  typedef struct packed {
    sdl_chain_st_t st;
    logic [LK_AW-1:0] ptr;
    logic fetch;
    logic empty;
  } sdl_chain_t;

  // reports from the dma datapath, one-cycle pulses unless noted
  typedef struct packed {
    logic tx_desc_ok;
    logic tx_desc_err;
    logic tx_desc_done;
    logic [LK_AW-1:0] tx_next;
    logic rx_desc_ok;
    logic rx_desc_err;
    logic rx_desc_done;
    logic [LK_AW-1:0] rx_next;
    logic rx_invalid;
    logic tx_pushed;
    logic tx_popped;
    logic tx_total_eof;
    logic tx_done;
    logic rx_good_eof;
    logic rx_done;
  } sdl_dp_in_t;

  typedef struct packed {
    logic tx_fetch;
    logic [LK_AW-1:0] tx_addr;
    logic rx_fetch;
    logic [LK_AW-1:0] rx_addr;
    logic tx_run;
    logic rx_run;
    logic data_burst;
    logic txd_burst;
    logic rxd_burst;
    logic bm_rst;
    logic fifo_rst;
    logic out_rst;
    logic in_rst;
  } sdl_dp_out_t;

  typedef struct packed {
    logic [DW-1:0] conf;
    logic [DW-1:0] txl;
    logic [DW-1:0] rxl;
    logic [NEV-1:0] ena;
    logic [NEV-1:0] raw;
    logic [NEV-1:0] masked;
    sdl_chain_t tx;
    sdl_chain_t rx;
    logic [DW-1:0] rdata;
  } sdl_state_t;
endpackage : sdl_pkg
